// >>> verilog/pbb_bridge.sv
// Purpose: Processor to system bus bridge with command and status ports.
// Assumes: All inputs synchronous to clock; bus answers with sys_ack.
// Notes:   One bus cycle at a time; jumpers are static straps.
`timescale 1ns/1ps
module pbb_bridge
    import pbb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    // Register access port
    input  wire logic [1:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Straps and processor status
    input  wire logic [2:0]  jmp_flags,
    input  wire logic        jmp_bus8,
    input  wire logic        jmp_lock,
    input  wire logic        proc_fatal,
    // Processor control
    output logic             proc_hold_init,
    output logic             proc_alarm,
    output logic             fault_lamp,
    output logic             sys_int_req,
    // Processor packet bus
    input  wire logic        pkt_start,
    input  wire logic [15:0] pkt_data,
    input  wire logic [15:0] proc_wdata,
    input  wire logic        proc_wdata_valid,
    output logic             proc_wdata_take,
    output logic      [15:0] proc_rdata,
    output logic             proc_rdata_valid,
    output logic             proc_done,
    // System bus master side
    output logic             sys_req_valid,
    output pbb_cycle_s       sys_req,
    input  wire logic        sys_ack,
    input  wire logic [15:0] sys_rdata,
    output logic             sys_lock
);

    // Byte count for a length code; unused codes act as one byte
    function automatic logic [3:0] len_bytes(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h1;
        case (code)
            PBB_LEN_2:  n = 4'h2;
            PBB_LEN_4:  n = 4'h4;
            PBB_LEN_6:  n = 4'h6;
            PBB_LEN_8:  n = 4'h8;
            PBB_LEN_10: n = 4'ha;
            default:    n = 4'h1;
        endcase
        return n;
    endfunction

    // Control state
    logic [7:0]  cmd_reg;
    logic [7:0]  cmd_next;
    logic [7:0]  offset_reg;
    logic [7:0]  rdata_reg;
    logic        alarm_reg;
    logic        fatal_reg;
    pbb_state_e  state_reg;
    pbb_state_e  state_next;
    logic [7:0]  op_reg;
    logic [7:0]  alo_reg;
    logic [3:0]  left_reg;
    logic [3:0]  left_next;
    logic        word_reg;
    logic        lane_reg;
    logic        lane_next;
    logic        active_reg;
    logic [15:0] wbuf_reg;
    logic [15:0] rbuf_reg;
    logic [15:0] rbuf_next;
    logic [15:0] prdata_reg;
    logic        prvalid_reg;
    logic        done_reg;

    // Decoded signals
    logic        wr_cmd;
    logic        wr_ofs;
    logic        run;
    logic        stop_cmd;
    logic        stopped;
    logic [7:0]  status;
    logic [7:0]  rd_mux;
    logic        op_write;
    logic        op_local;
    logic [3:0]  len_n;
    logic [23:0] full_addr;
    logic        word_mode;
    logic        load_addr;
    logic        cycle_end;
    logic [3:0]  dec_amt;
    logic        word_full;
    logic        last;
    logic [19:0] bus_addr;
    logic [15:0] cyc_wdata;

    // Register decode
    // command and offset ports
    assign wr_cmd = reg_wr && (reg_addr == PBB_OFS_COMMAND);
    assign wr_ofs = reg_wr && (reg_addr == PBB_OFS_OFFSET);

    assign run            = cmd_reg[PBB_CMD_RUN];
    assign proc_hold_init = ~run;
    assign stop_cmd       = cmd_reg[PBB_CMD_STOP];

    // stopped once no bus cycle is in flight
    assign stopped = stop_cmd && !active_reg;

    // Status word assembly
    // hold flag
    assign status = {jmp_flags, fatal_reg, 1'b0, stopped,
                     cmd_reg[PBB_CMD_INT], ~run};

    // Read selection; command register is write-only and reads zero
    assign rd_mux = (reg_addr == PBB_OFS_STATUS) ? status
                  : (reg_addr == PBB_OFS_OFFSET) ? offset_reg
                  : 8'h00;

    // Command update; alarm bit self-clears after its pulse
    // alarm self-clear
    always_comb
    begin
        cmd_next = cmd_reg;
        if (wr_cmd)
            cmd_next = reg_wdata;
        // A fresh alarm write wins over the self-clear
        if (alarm_reg && !(wr_cmd && reg_wdata[PBB_CMD_ALARM]))
            cmd_next[PBB_CMD_ALARM] = 1'b0;
    end

    // Register file
    // command clears on reset
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cmd_reg    <= PBB_CMD_RESET;
            offset_reg <= PBB_OFFSET_RESET;
            rdata_reg  <= 8'h00;
            alarm_reg  <= 1'b0;
            fatal_reg  <= 1'b0;
        end
        else
        begin
            cmd_reg    <= cmd_next;
            offset_reg <= wr_ofs ? reg_wdata : offset_reg;
            rdata_reg  <= reg_rd ? rd_mux : rdata_reg;
            alarm_reg  <= cmd_reg[PBB_CMD_ALARM] && !alarm_reg;
            fatal_reg  <= proc_fatal;
        end
    end

    assign reg_rdata  = rdata_reg;
    assign proc_alarm = alarm_reg;
    assign fault_lamp  = fatal_reg;
    assign sys_int_req = cmd_reg[PBB_CMD_INT];

    // Packet decode
    // two-word capture
    assign op_write  = op_reg[PBB_OP_WRITE];
    assign op_local  = op_reg[PBB_OP_LOCAL];
    assign full_addr = {pkt_data, alo_reg};
    assign len_n     = len_bytes(op_reg[PBB_OP_LEN_LO +: 3]);
    assign word_mode = !jmp_bus8 && (len_n != 4'h1) && !alo_reg[0];
    assign load_addr = (state_reg == PBB_ADDR_HI);

    // Bus cycle bookkeeping
    assign cycle_end = (state_reg == PBB_ISSUE) && sys_req_valid && sys_ack;
    assign dec_amt   = word_reg ? 4'h2 : 4'h1;
    assign left_next = left_reg - dec_amt;
    assign last      = (left_next == 4'h0);
    assign word_full = word_reg || lane_reg || last;

    pbb_addr_gen u_addr (
        .clock     (clock),
        .rst       (rst),
        .load      (load_addr),
        .proc_addr (full_addr),
        .is_local  (op_local),
        .offset    (offset_reg),
        .step      (cycle_end),
        .step_two  (word_reg),
        .bus_addr  (bus_addr)
    );

    // Read assembly: byte cycles fill low then high half
    always_comb
    begin
        rbuf_next = rbuf_reg;
        if (word_reg)
            rbuf_next = sys_rdata;
        else if (lane_reg)
            rbuf_next[15:8] = sys_rdata[7:0];
        else
            rbuf_next = {8'h00, sys_rdata[7:0]};
    end

    // Next state
    always_comb
    begin
        state_next = state_reg;
        lane_next  = lane_reg;
        unique case (state_reg)
            PBB_IDLE:
                if (pkt_start && run)
                    state_next = PBB_ADDR_HI;
            PBB_ADDR_HI:
            begin
                lane_next  = 1'b0;
                state_next = op_write ? PBB_FETCH : PBB_ISSUE;
            end
            PBB_FETCH:
                if (proc_wdata_valid)
                    state_next = PBB_ISSUE;
            PBB_ISSUE:
                if (cycle_end)
                begin
                    lane_next = !word_full;
                    if (last)
                        state_next = PBB_IDLE;
                    else if (word_full && op_write)
                        state_next = PBB_FETCH;
                end
        endcase
        if (!run)
            state_next = PBB_IDLE;
    end

    // Transfer sequencer
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg   <= PBB_IDLE;
            op_reg      <= 8'h00;
            alo_reg     <= 8'h00;
            left_reg    <= 4'h0;
            word_reg    <= 1'b0;
            lane_reg    <= 1'b0;
            wbuf_reg    <= 16'h0000;
            rbuf_reg    <= 16'h0000;
            prdata_reg  <= 16'h0000;
            prvalid_reg <= 1'b0;
            done_reg    <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            lane_reg    <= lane_next;
            prvalid_reg <= cycle_end && !op_write && word_full;
            done_reg    <= cycle_end && last;
            if (state_reg == PBB_IDLE && pkt_start)
            begin
                op_reg  <= pkt_data[15:8];
                alo_reg <= pkt_data[7:0];
            end
            if (load_addr)
            begin
                left_reg <= len_n;
                word_reg <= word_mode;
            end
            if (proc_wdata_take)
                wbuf_reg <= proc_wdata;
            if (cycle_end)
            begin
                left_reg <= left_next;
                rbuf_reg <= rbuf_next;
            end
            if (cycle_end && !op_write && word_full)
                prdata_reg <= rbuf_next;
        end
    end

    // Bus request held until acknowledged; stop only blocks a new one
    // no new cycle while stopped
    always_ff @(posedge clock)
    begin
        if (rst)
            active_reg <= 1'b0;
        else if (cycle_end || state_reg != PBB_ISSUE)
            active_reg <= 1'b0;
        else if (sys_req_valid)
            active_reg <= 1'b1;
    end

    assign sys_req_valid = (state_reg == PBB_ISSUE) &&
                           (active_reg || !stop_cmd);

    // Cycle data lane select
    assign cyc_wdata = word_reg ? wbuf_reg
                     : {8'h00, lane_reg ? wbuf_reg[15:8] : wbuf_reg[7:0]};

    // local to I/O, physical to memory
    assign sys_req.addr  = bus_addr;
    assign sys_req.io    = op_local;
    assign sys_req.write = op_write;
    assign sys_req.word  = word_reg;
    assign sys_req.wdata = cyc_wdata;

    assign sys_lock = jmp_lock && (state_reg != PBB_IDLE) &&
                      (state_reg != PBB_ADDR_HI);

    // Processor side handshake
    assign proc_wdata_take  = (state_reg == PBB_FETCH) && proc_wdata_valid;
    assign proc_rdata       = prdata_reg;
    assign proc_rdata_valid = prvalid_reg;
    assign proc_done        = done_reg;

endmodule

// >>> verilog/pbb_pkg.sv
// Purpose: Shared constants and types for the processor bus bridge.
// Assumes: One 40 MHz clock, synchronous active-high reset.
// Notes:   Register indices, bit positions, reset values and length codes.
package pbb_pkg;

    // Register indices on the register access port
    localparam logic [1:0] PBB_OFS_STATUS  = 2'h0;
    localparam logic [1:0] PBB_OFS_COMMAND = 2'h1;
    localparam logic [1:0] PBB_OFS_OFFSET  = 2'h2;

    // Command register bit positions
    localparam int PBB_CMD_RUN   = 0;
    localparam int PBB_CMD_INT   = 1;
    localparam int PBB_CMD_IPC   = 2;
    localparam int PBB_CMD_STOP  = 3;
    localparam int PBB_CMD_ALARM = 4;

    // Status register bit positions
    localparam int PBB_ST_HOLD    = 0;
    localparam int PBB_ST_INT     = 1;
    localparam int PBB_ST_STOPPED = 2;
    localparam int PBB_ST_FATAL   = 4;
    localparam int PBB_ST_JMP_LO  = 5;

    // Reset values
    localparam logic [7:0] PBB_CMD_RESET    = 8'h00;
    localparam logic [7:0] PBB_OFFSET_RESET = 8'h00;

    // Control byte of the first packet word
    localparam int PBB_OP_WRITE  = 0;
    localparam int PBB_OP_LOCAL  = 1;
    localparam int PBB_OP_LEN_LO = 2;

    // Length specifier codes
    localparam logic [2:0] PBB_LEN_1  = 3'h0;
    localparam logic [2:0] PBB_LEN_2  = 3'h1;
    localparam logic [2:0] PBB_LEN_4  = 3'h2;
    localparam logic [2:0] PBB_LEN_6  = 3'h3;
    localparam logic [2:0] PBB_LEN_8  = 3'h4;
    localparam logic [2:0] PBB_LEN_10 = 3'h5;

    // Transfer state machine
    typedef enum logic [1:0] {
        PBB_IDLE    = 2'b00,
        PBB_ADDR_HI = 2'b01,
        PBB_FETCH   = 2'b10,
        PBB_ISSUE   = 2'b11
    } pbb_state_e;

    // One system bus cycle request
    typedef struct packed {
        logic [19:0] addr;
        logic        io;
        logic        write;
        logic        word;
        logic [15:0] wdata;
    } pbb_cycle_s;

endpackage

// >>> verilog/pbb_addr_gen.sv
// Purpose: Bus address counter: truncation, relocation and stepping.
// Assumes: Load and step never occur in the same cycle.
// Notes:   Upper four processor address bits are dropped.
`timescale 1ns/1ps
module pbb_addr_gen
    import pbb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [23:0] proc_addr,
    input  wire logic        is_local,
    input  wire logic [7:0]  offset,
    input  wire logic        step,
    input  wire logic        step_two,
    output logic      [19:0] bus_addr
);

    logic [19:0] addr_reg;
    logic [19:0] addr_next;
    logic [7:0]  upper_reloc;
    logic [7:0]  upper_sel;
    logic [19:0] step_amt;

    // Memory references are moved up by the offset; I/O stays put
    assign upper_reloc = proc_addr[19:12] + offset;
    assign upper_sel   = is_local ? proc_addr[19:12] : upper_reloc;
    assign step_amt    = step_two ? 20'h00002 : 20'h00001;
    assign addr_next   = load ? {upper_sel, proc_addr[11:0]}
                       : step ? addr_reg + step_amt
                       : addr_reg;
    assign bus_addr    = addr_reg;

    // Address counter
    always_ff @(posedge clock)
    begin
        if (rst)
            addr_reg <= 20'h00000;
        else
            addr_reg <= addr_next;
    end

endmodule

// >>> bench/pbb_bridge_chk.sv
// Purpose: Port-level assertions for the bridge.
// Assumes: Bound to pbb_bridge, one clock domain.
// Notes:   Watches outputs against register writes and straps.
`timescale 1ns/1ps
module pbb_bridge_chk
    import pbb_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [1:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] jmp_flags,
    input wire logic       jmp_bus8,
    input wire logic       jmp_lock,
    input wire logic       proc_fatal,
    input wire logic       proc_hold_init,
    input wire logic       proc_alarm,
    input wire logic       fault_lamp,
    input wire logic       sys_int_req,
    input wire logic       sys_req_valid,
    input wire pbb_cycle_s sys_req,
    input wire logic       sys_ack,
    input wire logic       sys_lock
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Command and status access decode
    wire logic cmd_wr   = reg_wr && reg_addr == PBB_OFS_COMMAND;
    wire logic alarm_wr = cmd_wr && reg_wdata[PBB_CMD_ALARM];
    wire logic st_rd    = reg_rd && reg_addr == PBB_OFS_STATUS;

    a_hold_follows: assert property (cmd_wr |=>
        proc_hold_init == !$past(reg_wdata[PBB_CMD_RUN]))
        else $error("hold output wrong after command write");
    a_int_follows: assert property (cmd_wr |=>
        sys_int_req == $past(reg_wdata[PBB_CMD_INT]))
        else $error("interrupt request wrong after write");
    a_alarm_issue: assert property (alarm_wr |->
        ##2 proc_alarm ##1 !proc_alarm)
        else $error("alarm pulse missing or too long");
    a_alarm_cause: assert property ($rose(proc_alarm) |->
        $past(alarm_wr, 2))
        else $error("alarm without command");
    a_lamp_copy: assert property ($rose(proc_fatal) |=> fault_lamp)
        else $error("fault lamp not lit");
    a_valid_hold: assert property (sys_req_valid && !sys_ack |=>
        sys_req_valid && $stable(sys_req))
        else $error("bus request dropped before ack");
    a_byte_only: assert property (sys_req_valid && jmp_bus8 |->
        !sys_req.word)
        else $error("word cycle in byte mode");
    a_word_even: assert property (sys_req_valid && sys_req.word |->
        !sys_req.addr[0])
        else $error("word cycle at odd address");
    a_lock_jumper: assert property (sys_req_valid |->
        sys_lock == jmp_lock)
        else $error("bus lock disagrees with jumper");
    a_jumper_read: assert property (st_rd |=>
        reg_rdata[7:5] == $past(jmp_flags))
        else $error("jumper flags misread");

    c_word: cover property (sys_req_valid && sys_req.word && sys_ack);
    c_io: cover property (sys_req_valid && sys_req.io && sys_ack);
    c_alarm: cover property (proc_alarm);
endmodule

// >>> bench/pbb_bus_model.sv
// Purpose: System bus slave answering bridge cycles.
// Assumes: Wait states set by dly; data derived from address.
// Notes:   Idle data lines show the inverse of the last value.
`timescale 1ns/1ps
module pbb_bus_model
    import pbb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [3:0]  dly,
    input  wire logic        sys_req_valid,
    input  wire pbb_cycle_s  sys_req,
    output logic             sys_ack,
    output logic      [15:0] sys_rdata
);
    logic [3:0]  wait_reg;
    logic [15:0] last_reg;
    // Wait-state counter and last data memory
    always_ff @(posedge clock)
    begin
        wait_reg <= (rst || sys_ack) ? 4'h0 : wait_reg + 4'(sys_req_valid);
        last_reg <= rst ? 16'h0 : (sys_ack ? sys_rdata : last_reg);
    end
    // Answer once the wait count is reached
    assign sys_ack   = sys_req_valid && wait_reg == dly;
    assign sys_rdata = sys_ack ? {~sys_req.addr[7:0], sys_req.addr[7:0]}
                               : ~last_reg;
endmodule

// >>> bench/pbb_bridge_tb_top.sv
// Purpose: Self-checking bench for the bridge.
// Assumes: Bench acts as processor and register master.
// Notes:   Bus slave is a separate model.
`timescale 1ns/1ps
module pbb_bridge_tb_top
    import pbb_pkg::*;
;
    logic        clock, rst, reg_wr, reg_rd, jmp_bus8, jmp_lock;
    logic        proc_fatal, pkt_start, sys_ack, hold, alarm, lamp, irq;
    logic        take, rvalid, done, sys_req_valid, sys_lock;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, v;
    logic [3:0]  dly;
    logic [15:0] pkt_data, sys_rdata, rdata, last_rd;
    pbb_cycle_s  sys_req;
    pbb_cycle_s  cyc_q[$];
    int          n_fail, comparisons, n, l, m, o, n_word;
    int          nb[6] = '{1, 2, 4, 6, 8, 10};
    logic [2:0]  jf = 3'h5;

    pbb_bridge dut (.clock, .rst, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .jmp_flags(jf), .jmp_bus8, .jmp_lock,
        .proc_fatal, .proc_hold_init(hold), .proc_alarm(alarm),
        .fault_lamp(lamp), .sys_int_req(irq), .pkt_start, .pkt_data,
        .proc_wdata(16'ha5c3), .proc_wdata_valid(1'b1),
        .proc_wdata_take(take), .proc_rdata(rdata),
        .proc_rdata_valid(rvalid), .proc_done(done), .sys_req_valid,
        .sys_req, .sys_ack, .sys_rdata, .sys_lock);
    pbb_bus_model slave (.clock, .rst, .dly, .sys_req_valid, .sys_req,
        .sys_ack, .sys_rdata);

    always #12.5 clock = ~clock;
    // Log completed bus cycles and read words
    always @(posedge clock)
    begin
        if (sys_req_valid && sys_ack)
            cyc_q.push_back(sys_req);
        if (rvalid)
            last_rd <= rdata;
        // Processor words moved, written or read
        if (take || rvalid)
            n_word++;
    end

    task automatic report_and_stop;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [23:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        v = reg_rdata;
    endtask
    // Two packet words, then wait for completion
    task automatic xcheck(input logic [7:0] c, input logic [23:0] a,
                          input int cnt, input int st);
        int i;
        logic [19:0] ea;
        logic [19:0] la;
        logic [15:0] ew;
        cyc_q.delete();
        n_word = 0;
        @(posedge clock);
        pkt_start <= 1'b1;
        pkt_data <= {c, a[7:0]};
        @(posedge clock);
        pkt_start <= 1'b0;
        pkt_data <= a[23:8];
        for (i = 0; i < 400 && done !== 1'b1; i++)
            @(negedge clock);
        if (i == 400)
        begin
            n_fail++;
            report_and_stop();
        end
        @(negedge clock);
        ea = c[1] ? a[19:0] : {a[19:12] + 8'h30, a[11:0]};
        la = ea + 20'((cnt - 1) * st);
        chk("cycles", 24'(cnt), 24'(cyc_q.size()));
        chk("words", 24'((cnt * st + 1) / 2), 24'(n_word));
        for (i = 0; i < cyc_q.size(); i++)
        begin
            ew = (st == 2) ? 16'ha5c3 : (i[0] ? 16'h00a5 : 16'h00c3);
            chk("addr", 24'(ea + 20'(i * st)), 24'(cyc_q[i].addr));
            chk("kind", {22'h0, c[1:0]},
                {22'h0, cyc_q[i].io, cyc_q[i].write});
            chk("word", 24'(st == 2), 24'(cyc_q[i].word));
            if (c[0])
                chk("wlane", 24'(ew), 24'(cyc_q[i].wdata));
        end
        if (c[0] && cnt == 1)
            chk("wdata", 24'h0000c3, 24'(cyc_q[0].wdata[7:0]));
        // Last word read: word cycle, or low then high byte cycle
        if (!c[0] && st == 2)
            chk("rdata", 24'({~la[7:0], la[7:0]}), 24'(last_rd));
        ew = (cnt == 1) ? {8'h00, la[7:0]} : {la[7:0], la[7:0] - 8'h01};
        if (!c[0] && st == 1)
            chk("rbytes", 24'(ew), 24'(last_rd));
    endtask

    initial
    begin
        {clock, reg_wr, reg_rd, jmp_bus8, jmp_lock, proc_fatal} = 6'h0;
        {pkt_start, reg_addr, reg_wdata, pkt_data, dly} = 0;
        n_fail = 0;
        comparisons = 0;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(PBB_OFS_STATUS);
        chk("status", {16'h0, jf, 5'h01}, 24'(v & 8'hf7));
        rd(PBB_OFS_COMMAND);
        chk("command", 24'h0, 24'(v));
        rd(2'h3);
        chk("unmapped", 24'h0, 24'(v));
        wr(PBB_OFS_COMMAND, 8'h03);
        rd(PBB_OFS_STATUS);
        chk("status", {16'h0, jf, 5'h02}, 24'(v & 8'hf7));
        chk("irq", 24'h1, 24'(irq));
        wr(PBB_OFS_COMMAND, 8'h01);
        wr(PBB_OFS_COMMAND, 8'h11);
        for (n = 0; n < 4 && alarm !== 1'b1; n++)
            @(negedge clock);
        chk("alarm", 24'h1, 24'(alarm));
        wr(PBB_OFS_OFFSET, 8'h30);
        rd(PBB_OFS_OFFSET);
        chk("offset", 24'h30, 24'(v));
        // Every length, both modes, both alignments
        for (m = 0; m < 2; m++)
            for (o = 0; o < 2; o++)
                for (l = 0; l < 6; l++)
                begin
                    jmp_bus8 <= m[0];
                    jmp_lock <= o[0];
                    dly <= 4'(l % 3);
                    n = (!m[0] && !o[0] && l > 0) ? nb[l] / 2 : nb[l];
                    xcheck({3'h0, 3'(l), 1'b0, l[0]}, 24'h7abc10 + 24'(o),
                           n, (n == nb[l]) ? 1 : 2);
                end
        jmp_bus8 <= 1'b0;
        xcheck({3'h0, PBB_LEN_2, 2'b11}, 24'h012344, 1, 2);
        wr(PBB_OFS_COMMAND, 8'h09);
        rd(PBB_OFS_STATUS);
        chk("stopped", {16'h0, jf, 5'h04}, 24'(v & 8'hf7));
        fork
            xcheck({3'h0, PBB_LEN_1, 2'b00}, 24'h000101, 1, 1);
            begin
                repeat (10) @(posedge clock);
                chk("held off", 24'h0, 24'(cyc_q.size()));
                wr(PBB_OFS_COMMAND, 8'h01);
            end
        join
        @(posedge clock);
        proc_fatal <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        chk("lamp", 24'h1, 24'(lamp));
        rd(PBB_OFS_STATUS);
        chk("fatal", {16'h0, jf, 5'h10}, 24'(v & 8'hf7));
        // Re-initialize the processor after the fatal error
        wr(PBB_OFS_COMMAND, 8'h00);
        proc_fatal <= 1'b0;
        wr(PBB_OFS_COMMAND, 8'h01);
        // Command lands on the write edge; look once it has settled
        @(negedge clock);
        chk("hold", 24'h0, 24'(hold));
        report_and_stop();
    end
endmodule

bind pbb_bridge pbb_bridge_chk u_chk (.clock, .rst, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .jmp_flags, .jmp_bus8, .jmp_lock,
    .proc_fatal, .proc_hold_init, .proc_alarm, .fault_lamp,
    .sys_int_req, .sys_req_valid, .sys_req, .sys_ack, .sys_lock);
